/* File: rtcct_pkg.sv */
// Shared constants and carrier types for the calendar and trim block.
// Assumes a single 125 MHz system clock and an 8-bit internal register port.
package rtcct_pkg;

    // Internal register addresses
    localparam logic [3:0] ADDR_HOUR = 4'h2;
    localparam logic [3:0] ADDR_WDAY = 4'h3;
    localparam logic [3:0] ADDR_DAY = 4'h4;
    localparam logic [3:0] ADDR_MONTH = 4'h5;
    localparam logic [3:0] ADDR_YEAR = 4'h6;
    localparam logic [3:0] ADDR_TRIM = 4'h7;
    localparam logic [3:0] ADDR_ALARM_FIRST = 4'h8;
    localparam logic [3:0] ADDR_ALARM_LAST = 4'hD;

    // Implemented bits of each register; the rest read zero
    localparam logic [7:0] MASK_HOUR = 8'h3F;
    localparam logic [7:0] MASK_WDAY = 8'h07;
    localparam logic [7:0] MASK_DAY = 8'h3F;
    localparam logic [7:0] MASK_MONTH = 8'h1F;
    localparam logic [7:0] MASK_YEAR = 8'hFF;
    localparam logic [7:0] MASK_TRIM = 8'hFF;
    localparam logic [7:0] MASK_ALARM_MIN = 8'h7F;
    localparam logic [7:0] MASK_ALARM_HOUR = 8'h3F;
    localparam logic [7:0] MASK_ALARM_WDAY = 8'h7F;

    // Field positions
    localparam int TRIM_XSEL_BIT = 7;
    localparam int TRIM_SIGN_BIT = 6;
    localparam int HOUR_PM_BIT = 5;

    // Reset values
    localparam logic [7:0] RST_HOUR = 8'h00;
    localparam logic [2:0] RST_WDAY = 3'h0;
    localparam logic [7:0] RST_DAY = 8'h01;
    localparam logic [7:0] RST_MONTH = 8'h01;
    localparam logic [7:0] RST_YEAR = 8'h00;
    localparam logic [7:0] RST_TRIM = 8'h00;

    // Calendar limits in BCD
    localparam logic [7:0] BCD_00 = 8'h00;
    localparam logic [7:0] BCD_01 = 8'h01;
    localparam logic [7:0] BCD_12 = 8'h12;
    localparam logic [7:0] BCD_20 = 8'h20;
    localparam logic [7:0] BCD_23 = 8'h23;
    localparam logic [7:0] BCD_28 = 8'h28;
    localparam logic [7:0] BCD_29 = 8'h29;
    localparam logic [7:0] BCD_30 = 8'h30;
    localparam logic [7:0] BCD_31 = 8'h31;
    localparam logic [7:0] BCD_40 = 8'h40;
    localparam logic [7:0] BCD_99 = 8'h99;
    localparam logic [7:0] BCD_FEB = 8'h02;
    localparam logic [7:0] BCD_APR = 8'h04;
    localparam logic [7:0] BCD_JUN = 8'h06;
    localparam logic [7:0] BCD_SEP = 8'h09;
    localparam logic [7:0] BCD_NOV = 8'h11;
    localparam logic [2:0] WDAY_LAST = 3'h6;

    // Oscillator pulses per untrimmed second
    localparam logic [15:0] PULSES_32768 = 16'h8000;
    localparam logic [15:0] PULSES_32000 = 16'h7D00;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rtcct_req_type;

    // Calendar state
    typedef struct packed {
        logic [7:0] hour;
        logic [2:0] wday;
        logic [7:0] day;
        logic [7:0] month;
        logic [7:0] year;
    } rtcct_cal_type;

endpackage

/* File: rtcct_pin_filter.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module rtcct_pin_filter
    import rtcct_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Pin and filtered level
    input wire logic pin,
    output logic level
);

    logic s1_q; // First stage, read only by the second
    logic s2_q; // Second stage
    logic s3_q; // Third stage
    logic level_q; // Accepted level

    ////////////////////////////////////////////////////////////////
    // Shift chain
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            level_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end

    assign level = level_q;

endmodule
`default_nettype wire

/* File: rtcct_bcd_step.sv */
// One BCD step between a low and a high bound, with wrap flag.
// Assumes the current value is a valid BCD value within the bounds.
`timescale 1ns/1ps
`default_nettype none
module rtcct_bcd_step
    import rtcct_pkg::*;
(
    // Value and bounds
    input wire logic [7:0] cur,
    input wire logic [7:0] lo,
    input wire logic [7:0] hi,
    // Next value and wrap
    output logic [7:0] nxt,
    output logic wrap
);

    ////////////////////////////////////////////////////////////////
    // Wrap at the bound, carry units into tens at nine
    always_comb begin
        wrap = 1'b0;
        if (cur == hi) begin
            nxt = lo;
            wrap = 1'b1;
        end else if (cur[3:0] == 4'h9) begin
            nxt = {cur[7:4] + 4'h1, 4'h0};
        end else begin
            nxt = {cur[7:4], cur[3:0] + 4'h1};
        end
    end

endmodule
`default_nettype wire

/* File: rtcct_top.sv */
// Hour, weekday and BCD calendar counters with crystal select and trim.
// Assumes the seconds and minutes counters sit outside and feed
// sec_digits and min_carry on sys_clk; the serial bus front end drives
// the internal register port; the crystal arrives on osc_pin.
//
// Notes on behaviour
// - Weekday advances once on each day carry
// - Weekday counts 0 to 6 then wraps
// - Day wrap to one advances month
// - Month runs 1 to 12, wrap advances year
// - Year 00 to 99, multiples of four leap
// - Day, month, year kept as packed BCD
// - Trim reads zero while halt flag set
// - Bit seven selects 32768 or 32000 base
// - Untrimmed second is the base pulse count
// - Trim only at seconds 00, 20, 40
// - Positive sign lengthens by twice value-1
// - Negative sign shortens by twice inverted+1
// - Magnitude bits five to one zero: unchanged
// - Trim write takes effect next qualifying second
// - Clock output passes raw crystal untrimmed
// - Alarm A at 8h-Ah, alarm B Bh-Dh
// - Hour bit five is PM or twenty
// - Twelve-hour midnight 12, noon 32
// - Last hour rollover carries day and weekday
// - Halt flag clears select and trim bits
`timescale 1ns/1ps
`default_nettype none
module rtcct_top
    import rtcct_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Internal register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Neighbouring counters and control
    input wire logic [7:0] sec_digits,
    input wire logic min_carry,
    input wire logic hour_12_mode,
    input wire logic osc_halt_flag,
    // Crystal and timing outputs
    input wire logic osc_pin,
    output logic clk32_out,
    output logic sec_tick
);

    ////////////////////////////////////////////////////////////////
    // Declarations
    rtcct_req_type req; // Bundled register request
    rtcct_cal_type cal_q; // Calendar state, gathered from the registers below
    logic [7:0] hour_q, day_q, month_q, year_q; // Calendar digit registers, one writer each
    logic [2:0] wday_q; // Weekday code register
    logic [7:0] trim_q; // Crystal select and trim bits
    logic [7:0] alarm_q [6]; // Alarm A and B bytes
    logic [7:0] rdata_q; // Read data holder
    logic clk32_q; // Raw crystal copy
    logic tick_q; // One-second pulse
    logic osc_level; // Filtered crystal level
    logic osc_prev_q; // Previous crystal level
    logic osc_pulse; // Rising crystal edge
    logic [15:0] cnt_q; // Pulses within current second
    logic [15:0] period_q; // Pulses for current second
    logic [15:0] period_d; // Pulses chosen for a new second
    logic [15:0] base; // Untrimmed pulses
    logic [15:0] lengthen; // Added pulses
    logic [15:0] shorten; // Removed pulses
    logic qualify; // Seconds value takes trim
    logic second_end; // Last pulse of the second
    logic [7:0] h24_nxt; // Next hour, 24-hour
    logic h24_wrap; // 23 to 00
    logic [7:0] h12_nxt; // Next hour digits, 12-hour
    logic h12_wrap; // 12 to 01 step
    logic [7:0] hour_nxt; // Next hour
    logic day_carry; // Hour wraps into next day
    logic [7:0] day_last; // Last day of month
    logic leap; // Leap year flag
    logic [7:0] day_nxt; // Next day
    logic day_wrap; // Day back to one
    logic [7:0] mon_nxt; // Next month
    logic mon_wrap; // Month back to one
    logic [7:0] year_nxt; // Next year
    logic [2:0] wday_nxt; // Next weekday
    logic [3:0] alarm_idx; // Alarm byte index
    logic [7:0] alarm_mask; // Alarm write mask

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign cal_q = '{hour: hour_q, wday: wday_q, day: day_q, month: month_q, year: year_q};

    ////////////////////////////////////////////////////////////////
    // Crystal input
    rtcct_pin_filter u_osc_filter (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .pin(osc_pin),
        .level(osc_level)
    );

    // Edge detect on the filtered level
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_level;
        end
    end

    assign osc_pulse = osc_level & ~osc_prev_q;

    // Clock output copies the crystal, never the trimmed count
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk32_q <= 1'b0;
        end else begin
            clk32_q <= osc_level;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Second length selection
    always_comb begin
        base = trim_q[TRIM_XSEL_BIT] ? PULSES_32000 : PULSES_32768;
        qualify = (sec_digits == BCD_00) || (sec_digits == BCD_20) || (sec_digits == BCD_40);
        lengthen = {9'h000, trim_q[5:0] - 6'h01, 1'b0};
        shorten = {9'h000, ~trim_q[5:0] + 6'h01, 1'b0};
        period_d = base;
        if (qualify && (trim_q[5:1] != 5'h00)) begin
            if (trim_q[TRIM_SIGN_BIT]) begin
                period_d = base - shorten;
            end else begin
                period_d = base + lengthen;
            end
        end
    end

    assign second_end = osc_pulse && (cnt_q == period_q - 16'h0001);

    // Pulse counter; the period is latched at the first pulse of each second
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 16'h0000;
            period_q <= PULSES_32768;
        end else if (osc_pulse) begin
            if (cnt_q == 16'h0000) begin
                period_q <= period_d;
                cnt_q <= 16'h0001;
            end else if (second_end) begin
                cnt_q <= 16'h0000;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    // One-cycle second pulse to the seconds counter
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= second_end;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Hour stepping
    rtcct_bcd_step u_hour24 (
        .cur(cal_q.hour),
        .lo(BCD_00),
        .hi(BCD_23),
        .nxt(h24_nxt),
        .wrap(h24_wrap)
    );

    rtcct_bcd_step u_hour12 (
        .cur({3'h0, cal_q.hour[4:0]}),
        .lo(BCD_01),
        .hi(BCD_12),
        .nxt(h12_nxt),
        .wrap(h12_wrap)
    );

    // Twelve-hour: 11 flips AM/PM into 12; PM 11 (31) to AM 12 ends the day
    always_comb begin
        if (hour_12_mode) begin
            hour_nxt = {2'b00, cal_q.hour[HOUR_PM_BIT], h12_nxt[4:0]};
            day_carry = 1'b0;
            if (cal_q.hour[4:0] == 5'h11) begin
                hour_nxt = {2'b00, ~cal_q.hour[HOUR_PM_BIT], 5'h12};
                day_carry = cal_q.hour[HOUR_PM_BIT];
            end
        end else begin
            hour_nxt = h24_nxt;
            day_carry = h24_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Calendar stepping
    // Tens even: units 0,4,8; tens odd: units 2,6
    assign leap = cal_q.year[4] ? (cal_q.year[1:0] == 2'b10) : (cal_q.year[1:0] == 2'b00);

    // Month length
    always_comb begin
        if (cal_q.month == BCD_FEB) begin
            day_last = leap ? BCD_29 : BCD_28;
        end else if ((cal_q.month == BCD_APR) || (cal_q.month == BCD_JUN) ||
                     (cal_q.month == BCD_SEP) || (cal_q.month == BCD_NOV)) begin
            day_last = BCD_30;
        end else begin
            day_last = BCD_31;
        end
    end

    rtcct_bcd_step u_day (
        .cur(cal_q.day),
        .lo(BCD_01),
        .hi(day_last),
        .nxt(day_nxt),
        .wrap(day_wrap)
    );

    rtcct_bcd_step u_month (
        .cur(cal_q.month),
        .lo(BCD_01),
        .hi(BCD_12),
        .nxt(mon_nxt),
        .wrap(mon_wrap)
    );

    rtcct_bcd_step u_year (
        .cur(cal_q.year),
        .lo(BCD_00),
        .hi(BCD_99),
        .nxt(year_nxt),
        .wrap()
    );

    // Septimal weekday
    assign wday_nxt = (cal_q.wday == WDAY_LAST) ? 3'h0 : cal_q.wday + 3'h1;

    ////////////////////////////////////////////////////////////////
    // Hour register: host write wins over the minute carry
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hour_q <= RST_HOUR;
        end else if (req.wr && req.addr == ADDR_HOUR) begin
            hour_q <= req.wdata & MASK_HOUR;
        end else if (min_carry) begin
            hour_q <= hour_nxt;
        end
    end

    // Weekday register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wday_q <= RST_WDAY;
        end else if (req.wr && req.addr == ADDR_WDAY) begin
            wday_q <= req.wdata[2:0];
        end else if (min_carry && day_carry) begin
            wday_q <= wday_nxt;
        end
    end

    // Day register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            day_q <= RST_DAY;
        end else if (req.wr && req.addr == ADDR_DAY) begin
            day_q <= req.wdata & MASK_DAY;
        end else if (min_carry && day_carry) begin
            day_q <= day_nxt;
        end
    end

    // Month register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            month_q <= RST_MONTH;
        end else if (req.wr && req.addr == ADDR_MONTH) begin
            month_q <= req.wdata & MASK_MONTH;
        end else if (min_carry && day_carry && day_wrap) begin
            month_q <= mon_nxt;
        end
    end

    // Year register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            year_q <= RST_YEAR;
        end else if (req.wr && req.addr == ADDR_YEAR) begin
            year_q <= req.wdata & MASK_YEAR;
        end else if (min_carry && day_carry && day_wrap && mon_wrap) begin
            year_q <= year_nxt;
        end
    end

    // Trim register: halt flag forces it to zero
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            trim_q <= RST_TRIM;
        end else if (osc_halt_flag) begin
            trim_q <= RST_TRIM;
        end else if (req.wr && req.addr == ADDR_TRIM) begin
            trim_q <= req.wdata & MASK_TRIM;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Alarm bytes
    assign alarm_idx = req.addr - ADDR_ALARM_FIRST;

    // Minute, hour and weekday masks repeat for both alarms
    always_comb begin
        case (alarm_idx)
            4'h0, 4'h3: alarm_mask = MASK_ALARM_MIN;
            4'h1, 4'h4: alarm_mask = MASK_ALARM_HOUR;
            default: alarm_mask = MASK_ALARM_WDAY;
        endcase
    end

    // Storage at 8h to Dh
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 6; i++) begin
                alarm_q[i] <= 8'h00;
            end
        end else if (req.wr && req.addr >= ADDR_ALARM_FIRST && req.addr <= ADDR_ALARM_LAST) begin
            alarm_q[alarm_idx[2:0]] <= req.wdata & alarm_mask;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read data, held until the next read
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                ADDR_HOUR: rdata_q <= cal_q.hour;
                ADDR_WDAY: rdata_q <= {5'h00, cal_q.wday};
                ADDR_DAY: rdata_q <= cal_q.day;
                ADDR_MONTH: rdata_q <= cal_q.month;
                ADDR_YEAR: rdata_q <= cal_q.year;
                ADDR_TRIM: rdata_q <= osc_halt_flag ? 8'h00 : trim_q;
                4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD: rdata_q <= alarm_q[alarm_idx[2:0]];
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata = rdata_q;
    assign clk32_out = clk32_q;
    assign sec_tick = tick_q;

endmodule
`default_nettype wire

/* File: rtcct_top_asserts.sv */
// Concurrent checks on the calendar and trim block ports.
// Assumes binding onto every rtcct_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rtcct_top_asserts
    import rtcct_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Halt flag and crystal
    input wire logic osc_halt_flag,
    input wire logic osc_pin,
    input wire logic clk32_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////
    // Read data against address
    chk_unmapped_zero: assert property (
        reg_rd && (reg_addr < ADDR_HOUR || reg_addr > ADDR_ALARM_LAST) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_trim_halted: assert property (
        reg_rd && reg_addr == ADDR_TRIM && osc_halt_flag |=> reg_rdata == 8'h00)
        else $error("trim read not zero while halted");
    chk_hour_upper: assert property (
        reg_rd && reg_addr == ADDR_HOUR |=> reg_rdata[7:6] == 2'b00)
        else $error("hour upper bits set");
    chk_wday_legal: assert property (
        reg_rd && reg_addr == ADDR_WDAY |=> reg_rdata[7:3] == 5'h00 && reg_rdata[2:0] != 3'h7)
        else $error("weekday code out of range");
    chk_day_range: assert property (
        reg_rd && reg_addr == ADDR_DAY |=> reg_rdata inside {[8'h01:8'h31]} && reg_rdata[3:0] <= 4'h9)
        else $error("day out of range");
    chk_month_range: assert property (
        reg_rd && reg_addr == ADDR_MONTH |=> reg_rdata inside {[8'h01:8'h09], [8'h10:8'h12]})
        else $error("month out of range");
    chk_year_digits: assert property (
        reg_rd && reg_addr == ADDR_YEAR |=> reg_rdata[7:4] <= 4'h9 && reg_rdata[3:0] <= 4'h9)
        else $error("year not packed decimal");
    ////////////////////////////////////////////////////////////////
    // Clock output follows the raw crystal
    chk_clk32_rise: assert property (
        $rose(osc_pin) && !clk32_out |-> ##[1:10] $rose(clk32_out))
        else $error("clock output missed a rise");
    chk_clk32_fall: assert property (
        $fell(osc_pin) && clk32_out |-> ##[1:10] $fell(clk32_out))
        else $error("clock output missed a fall");
endmodule
bind rtcct_top rtcct_top_asserts u_chk (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .osc_halt_flag(osc_halt_flag), .osc_pin(osc_pin), .clk32_out(clk32_out)
);
`default_nettype wire

/* File: rtcct_host_model.sv */
// Host side of the register port: one-cycle write and read strobes.
// Assumes the bench calls its tasks at a rising edge.
`timescale 1ns/1ps
`default_nettype none
module rtcct_host_model
    import rtcct_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Request to the block
    output var rtcct_req_type req
);
    initial req = '0;
    // Write strobe; addr and data scrambled once released
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        if (a == ADDR_WDAY && d[2:0] == 3'h7) begin
            return;
        end
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask
    // Read strobe; data is seen by the bench monitor
    task automatic reg_read(input logic [3:0] a);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 8'h5A, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req <= '{addr: ~a, wdata: 8'hA5, wr: 1'b0, rd: 1'b0};
    endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the calendar and trim block.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %0t got %h want %h", $time, a, e); end end
module tb_top
    import rtcct_pkg::*;
;
    rtcct_req_type host_req; // Host request
    logic sys_clk = 1'b0, arst_n = 1'b0, min_carry = 1'b0, osc_pin = 1'b0;
    logic hour_12_mode = 1'b0, osc_halt_flag = 1'b0, rd_seen_q = 1'b0;
    logic [7:0] sec_digits = 8'h00, reg_rdata;
    logic clk32_out, sec_tick;
    logic [7:0] exp_q[$]; // Expected read data
    logic [7:0] exp_v; // Oldest note, popped once per read
    int num_errors = 0, checks = 0, cycles = 0;
    logic [7:0] ly; // Random leap year
    logic [7:0] wv [2:13] = '{8'hD1, 8'hFD, 8'hD5, 8'hE9, 8'h00, 8'h7E, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF};
    logic [7:0] mk [2:13] = '{MASK_HOUR, MASK_WDAY, MASK_DAY, MASK_MONTH, MASK_YEAR, MASK_TRIM,
        MASK_ALARM_MIN, MASK_ALARM_HOUR, MASK_ALARM_WDAY, MASK_ALARM_MIN, MASK_ALARM_HOUR, MASK_ALARM_WDAY};
    always #4 sys_clk = ~sys_clk;
    // Free crystal, unrelated to the system clock
    always #61 osc_pin = ~osc_pin;
    rtcct_host_model u_host (.sys_clk(sys_clk), .req(host_req));
    rtcct_top u_dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(host_req.addr), .reg_wdata(host_req.wdata),
        .reg_wr(host_req.wr), .reg_rd(host_req.rd), .reg_rdata(reg_rdata), .sec_digits(sec_digits),
        .min_carry(min_carry), .hour_12_mode(hour_12_mode), .osc_halt_flag(osc_halt_flag),
        .osc_pin(osc_pin), .clk32_out(clk32_out), .sec_tick(sec_tick)
    );
    ////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [7:0] bcd(input int v);
        bcd = {4'(v / 10), 4'(v % 10)};
    endfunction
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.reg_read(a);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        u_host.reg_write(a, d);
    endtask
    // Load calendar, one minute carry, read all back
    task automatic run_case(input rtcct_cal_type a, input rtcct_cal_type b, input logic m);
        hour_12_mode <= m;
        wr(ADDR_HOUR, a.hour);
        wr(ADDR_WDAY, {5'h00, a.wday});
        wr(ADDR_DAY, a.day);
        wr(ADDR_MONTH, a.month);
        wr(ADDR_YEAR, a.year);
        @(posedge sys_clk);
        min_carry <= 1'b1;
        @(posedge sys_clk);
        min_carry <= 1'b0;
        rd(ADDR_HOUR, b.hour);
        rd(ADDR_WDAY, {5'h00, b.wday});
        rd(ADDR_DAY, b.day);
        rd(ADDR_MONTH, b.month);
        rd(ADDR_YEAR, b.year);
    endtask
    task automatic end_of_test();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Monitor: read data one cycle after the strobe
    always @(posedge sys_clk) begin
        if (rd_seen_q) begin
            exp_v = exp_q.pop_front();
            `CHK(reg_rdata, exp_v)
        end
        // No second can end within this short run
        if (sec_tick !== 1'b0) begin
            `CHK(sec_tick, 1'b0)
        end
        rd_seen_q <= host_req.rd;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'hE8D3));
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        sec_digits <= bcd($urandom_range(0, 59));
        // Reset values; unmapped places ignore writes
        for (int i = 0; i < 16; i++) begin
            if (i < 2 || i > 13) begin
                wr(i[3:0], 8'hA5);
            end
            rd(i[3:0], (i == 4 || i == 5) ? 8'h01 : 8'h00);
        end
        // Every mapped place, upper bits dropped
        wv[6] = bcd($urandom_range(0, 99));
        for (int i = 2; i < 14; i++) begin
            wr(i[3:0], wv[i]);
        end
        for (int i = 2; i < 14; i++) begin
            rd(i[3:0], wv[i] & mk[i]);
        end
        // Carries through the calendar
        ly = bcd(4 * $urandom_range(0, 24));
        run_case('{8'h23, 3'h6, 8'h31, 8'h12, 8'h99}, '{8'h00, 3'h0, 8'h01, 8'h01, 8'h00}, 1'b0);
        run_case('{8'h23, 3'h2, 8'h28, 8'h02, ly}, '{8'h00, 3'h3, 8'h29, 8'h02, ly}, 1'b0);
        run_case('{8'h23, 3'h3, 8'h29, 8'h02, ly}, '{8'h00, 3'h4, 8'h01, 8'h03, ly}, 1'b0);
        run_case('{8'h23, 3'h0, 8'h28, 8'h02, 8'h01}, '{8'h00, 3'h1, 8'h01, 8'h03, 8'h01}, 1'b0);
        run_case('{8'h23, 3'h1, 8'h30, 8'h04, 8'h02}, '{8'h00, 3'h2, 8'h01, 8'h05, 8'h02}, 1'b0);
        run_case('{8'h23, 3'h4, 8'h30, 8'h11, 8'h03}, '{8'h00, 3'h5, 8'h01, 8'h12, 8'h03}, 1'b0);
        run_case('{8'h23, 3'h5, 8'h30, 8'h01, 8'h05}, '{8'h00, 3'h6, 8'h31, 8'h01, 8'h05}, 1'b0);
        run_case('{8'h19, 3'h5, 8'h31, 8'h01, 8'h05}, '{8'h20, 3'h5, 8'h31, 8'h01, 8'h05}, 1'b0);
        run_case('{8'h31, 3'h6, 8'h15, 8'h07, 8'h10}, '{8'h12, 3'h0, 8'h16, 8'h07, 8'h10}, 1'b1);
        run_case('{8'h11, 3'h0, 8'h15, 8'h07, 8'h10}, '{8'h32, 3'h0, 8'h15, 8'h07, 8'h10}, 1'b1);
        run_case('{8'h32, 3'h0, 8'h15, 8'h07, 8'h10}, '{8'h21, 3'h0, 8'h15, 8'h07, 8'h10}, 1'b1);
        // Halt flag clears trim and blocks writes
        @(posedge sys_clk);
        osc_halt_flag <= 1'b1;
        rd(ADDR_TRIM, 8'h00);
        wr(ADDR_TRIM, 8'h55);
        @(posedge sys_clk);
        osc_halt_flag <= 1'b0;
        rd(ADDR_TRIM, 8'h00);
        wr(ADDR_TRIM, 8'h81);
        rd(ADDR_TRIM, 8'h81);
        // Second reset in mid-run
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(ADDR_DAY, RST_DAY);
        rd(ADDR_TRIM, RST_TRIM);
        repeat (4) @(posedge sys_clk);
        end_of_test();
    end
endmodule
`undef CHK
`default_nettype wire
